// >>> src/mcg_clock_gen.v
// oscillator selection, cpu clock divider, peripheral clock, clock output and wake-up delay
//
// Contract
// - a machine cycle spans two cpu clock cycles.
// - peripheral clock runs at half the cpu clock.
// - selected oscillator clock feeds the divider; its output is the cpu clock.
// - internal rc oscillator, nominal 7.373 MHz, selectable by flash configuration.
// - clock output enable drives clock output pin at half cpu clock.
// - clock output only when crystal drives neither cpu nor real-time clock.
// - 6-bit rc tuning value, factory loaded, writable by software.
// - only power-on reset reloads the tuning value.
// - low-power select bit clears on any reset; software sets it only at <=8 MHz.
// - 400 kHz watchdog oscillator selectable as cpu clock source.
// - external clock mode takes crystal-input pin, 0 to 18 MHz.
// - wake-up holds cpu clock: crystal needs 992 osc cycles plus 60-100 us.
// - divider factor reaches at most 510.
// - divider writes take effect any time without stalling execution.
// - crystal ranges: low 20-100 kHz, medium 100 kHz-4 MHz, high 4-18 MHz.
// - divider register at address 95H, resets to 00.
`timescale 1ns/1ns
`include "mcg_map.vh"
module mcg_clock_gen #(
	parameter WAKE_MIN_CYCLES = `MCG_WAKE_MIN_CYCLES,
	parameter WAKE_OSC_CYCLES = `MCG_WAKE_OSC_CYCLES
)(
	input wire core_clk_i,
	input wire rst_i,
	input wire por_i,
	input wire [2:0] cfg_source_i,
	input wire rtc_uses_xtal_i,
	input wire rc_osc_clock_i,
	input wire wdog_osc_clock_i,
	input wire crystal_in_pin_i,
	input wire wake_i,
	input wire sfr_wr_i,
	input wire sfr_rd_i,
	input wire [7:0] sfr_addr_i,
	input wire [7:0] sfr_wdata_i,
	output reg [7:0] sfr_rdata_o,
	output reg sfr_hit_o,
	output reg cpu_clock_o,
	output reg periph_clock_o,
	output reg machine_cycle_o,
	output reg clock_output_pin_o,
	output reg clock_output_pin_oe_o,
	output reg [5:0] rc_osc_tune_o,
	output reg low_power_clock_select_o,
	output wire cpu_clock_ready_o
);
	localparam WAIT_IDLE = 2'b00;
	localparam WAIT_OSC = 2'b01;
	localparam WAIT_TIME = 2'b10;
	// pin-level clocks are sampled; edges seen here are core-domain events
	reg [2:0] meta;
	reg [2:0] sync;
	reg [2:0] sync_d;
	reg [2:0] src_q;
	reg [7:0] cpu_clock_divider;
	reg clock_out_enable;
	reg [7:0] div_cnt;
	reg osc_tick_q;
	reg cpu_tick;
	reg [1:0] wake_state;
	reg [12:0] wake_cnt;
	reg [1:0] next_wake_state;
	reg pclk_phase;
	wire rc_edge = sync[0] & ~sync_d[0];
	wire wd_edge = sync[1] & ~sync_d[1];
	wire xt_edge = sync[2] & ~sync_d[2];
	wire src_xtal = (src_q == `MCG_SRC_XTAL_LOW) | (src_q == `MCG_SRC_XTAL_MED) |
		(src_q == `MCG_SRC_XTAL_HIGH);
	reg osc_tick;
	always @*
	begin
		case (src_q)
			`MCG_SRC_RC: osc_tick = rc_edge;
			`MCG_SRC_WDOG: osc_tick = wd_edge;
			`MCG_SRC_XTAL_LOW, `MCG_SRC_XTAL_MED, `MCG_SRC_XTAL_HIGH: osc_tick = xt_edge;
			`MCG_SRC_EXT: osc_tick = xt_edge;
			default: osc_tick = rc_edge;
		endcase
	end
	always @(posedge core_clk_i)
	begin
		meta <= {crystal_in_pin_i, wdog_osc_clock_i, rc_osc_clock_i};
		sync <= meta;
		sync_d <= sync;
		osc_tick_q <= osc_tick;
	end
	// register file; tuning survives non-power-on resets
	always @(posedge core_clk_i)
	begin
		if (por_i)
		begin
			rc_osc_tune_o <= `MCG_TUNING_FACTORY;
			clock_out_enable <= 1'b0;
		end
		else if (sfr_wr_i && sfr_addr_i == `MCG_ADDR_TUNING)
		begin
			rc_osc_tune_o <= sfr_wdata_i[`MCG_TUNE_MSB:`MCG_TUNE_LSB];
			clock_out_enable <= sfr_wdata_i[`MCG_CLOCK_OUTPUT_PIN_EN_BIT];
		end
	end
	always @(posedge core_clk_i)
	begin
		if (rst_i || por_i)
		begin
			src_q <= `MCG_SRC_RC;
			cpu_clock_divider <= `MCG_DIVIDER_RESET;
			low_power_clock_select_o <= 1'b0;
		end
		else
		begin
			src_q <= cfg_source_i;
			if (sfr_wr_i && sfr_addr_i == `MCG_ADDR_DIVIDER)
				cpu_clock_divider <= sfr_wdata_i;
			if (sfr_wr_i && sfr_addr_i == `MCG_ADDR_AUX)
				low_power_clock_select_o <= sfr_wdata_i[`MCG_LOWPWR_BIT];
		end
	end
	always @*
	begin
		sfr_hit_o = 1'b1;
		case (sfr_addr_i)
			`MCG_ADDR_DIVIDER: sfr_rdata_o = cpu_clock_divider;
			`MCG_ADDR_TUNING: sfr_rdata_o = {1'b0, clock_out_enable, rc_osc_tune_o};
			`MCG_ADDR_AUX: sfr_rdata_o = {low_power_clock_select_o, 7'h00};
			default:
			begin
				sfr_rdata_o = 8'h00;
				sfr_hit_o = 1'b0;
			end
		endcase
		if (!sfr_rd_i && !sfr_wr_i)
			sfr_hit_o = 1'b0;
	end
	// wake-up hold: crystal waits osc cycles then a fixed time
	always @*
	begin
		next_wake_state = wake_state;
		case (wake_state)
			WAIT_IDLE: if (wake_i) next_wake_state = src_xtal ? WAIT_OSC : WAIT_IDLE;
			WAIT_OSC: if (osc_tick && wake_cnt == WAKE_OSC_CYCLES - 1) next_wake_state = WAIT_TIME;
			WAIT_TIME: if (wake_cnt == WAKE_MIN_CYCLES - 1) next_wake_state = WAIT_IDLE;
			default: next_wake_state = WAIT_IDLE;
		endcase
	end
	always @(posedge core_clk_i)
	begin
		if (rst_i || por_i)
		begin
			wake_state <= WAIT_IDLE;
			wake_cnt <= 13'h0000;
		end
		else
		begin
			wake_state <= next_wake_state;
			if (next_wake_state != wake_state)
				wake_cnt <= 13'h0000;
			else if (wake_state == WAIT_TIME || (wake_state == WAIT_OSC && osc_tick))
				wake_cnt <= wake_cnt + 13'h0001;
		end
	end
	assign cpu_clock_ready_o = (wake_state == WAIT_IDLE);
	// divider: toggle every N osc ticks gives divide by 2N
	always @(posedge core_clk_i)
	begin
		if (rst_i || por_i)
		begin
			div_cnt <= 8'h00;
			cpu_clock_o <= 1'b0;
			cpu_tick <= 1'b0;
		end
		else
		begin
			cpu_tick <= 1'b0;
			if (!cpu_clock_ready_o)
				div_cnt <= 8'h00;
			else if (cpu_clock_divider == 8'h00)
			begin
				cpu_clock_o <= osc_tick;
				cpu_tick <= osc_tick_q;
			end
			else if (osc_tick)
			begin
				// counter compared with >= so a smaller new value never stalls
				if (div_cnt >= cpu_clock_divider - 8'h01)
				begin
					div_cnt <= 8'h00;
					cpu_clock_o <= ~cpu_clock_o;
					cpu_tick <= ~cpu_clock_o;
				end
				else
					div_cnt <= div_cnt + 8'h01;
			end
		end
	end
	always @(posedge core_clk_i)
	begin
		if (rst_i || por_i)
		begin
			pclk_phase <= 1'b0;
			periph_clock_o <= 1'b0;
			machine_cycle_o <= 1'b0;
			clock_output_pin_o <= 1'b0;
			clock_output_pin_oe_o <= 1'b0;
		end
		else
		begin
			machine_cycle_o <= 1'b0;
			if (cpu_tick)
			begin
				pclk_phase <= ~pclk_phase;
				periph_clock_o <= ~pclk_phase;
				machine_cycle_o <= pclk_phase;
				clock_output_pin_o <= ~pclk_phase;
			end
			clock_output_pin_oe_o <= clock_out_enable & ~src_xtal & ~rtc_uses_xtal_i;
		end
	end
endmodule

// >>> src/mcg_map.vh
// register addresses, field positions, reset values and timing counts for the clock block
`ifndef MCG_MAP_VH
`define MCG_MAP_VH
`define MCG_ADDR_DIVIDER 8'h95
`define MCG_ADDR_TUNING 8'h96
`define MCG_ADDR_AUX 8'hA2
`define MCG_DIVIDER_RESET 8'h00
`define MCG_TUNING_FACTORY 6'h20
`define MCG_TUNE_LSB 0
`define MCG_TUNE_MSB 5
`define MCG_CLOCK_OUTPUT_PIN_EN_BIT 6
`define MCG_LOWPWR_BIT 7
`define MCG_SRC_RC 3'h0
`define MCG_SRC_WDOG 3'h1
`define MCG_SRC_XTAL_LOW 3'h2
`define MCG_SRC_XTAL_MED 3'h3
`define MCG_SRC_XTAL_HIGH 3'h4
`define MCG_SRC_EXT 3'h5
`define MCG_WAKE_OSC_CYCLES 992
`define MCG_WAKE_MIN_US 60
`define MCG_CLK_MHZ 100
`define MCG_WAKE_MIN_CYCLES (`MCG_WAKE_MIN_US * `MCG_CLK_MHZ)
`endif

// >>> dv/mcg_osc_model.sv
// oscillator sources driving the clock block
`timescale 1ns/1ns
module mcg_osc_model (
	output bit rc_o,
	output bit wd_o,
	output bit xt_o
);
	// free-running sources, so they are never parked between uses
	always #68 rc_o = ~rc_o;
	always #1250 wd_o = ~wd_o;
	// above 12 MHz; the configuration is taken to enable the reset pin
	always #30 xt_o = ~xt_o;
endmodule

// >>> dv/mcg_clock_gen_sva.sv
// port assertions for the clock block
`timescale 1ns/1ns
module mcg_sva (
	input core_clk_i,
	input rst_i,
	input por_i,
	input [2:0] cfg_source_i,
	input rtc_uses_xtal_i,
	input wake_i,
	input sfr_wr_i,
	input sfr_rd_i,
	input [7:0] sfr_addr_i,
	input [7:0] sfr_wdata_i,
	input [7:0] sfr_rdata_o,
	input sfr_hit_o,
	input clock_output_pin_oe_o,
	input [5:0] rc_osc_tune_o,
	input low_power_clock_select_o,
	input cpu_clock_ready_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	a_map_read:
	assert property (sfr_rd_i && !(sfr_addr_i inside {8'h95, 8'h96, 8'hA2}) |-> !sfr_hit_o
		&& sfr_rdata_o == 8'h00) else $error("unmapped read");
	a_div_back:
	assert property (sfr_wr_i && sfr_addr_i == 8'h95 ##1 sfr_rd_i && sfr_addr_i == 8'h95
		|-> sfr_rdata_o == $past(sfr_wdata_i)) else $error("divider readback");
	a_tune_wr:
	assert property (sfr_wr_i && sfr_addr_i == 8'h96 |=> {2'b00, rc_osc_tune_o}
		== ($past(sfr_wdata_i) & 8'h3F)) else $error("tune write");
	a_tune_keep:
	assert property (disable iff (por_i) rst_i |=> $stable(rc_osc_tune_o)) else $error("tune lost");
	a_lp_clear:
	assert property ($fell(rst_i) |-> !low_power_clock_select_o) else $error("low power set");
	a_out_gate:
	assert property ((rtc_uses_xtal_i || cfg_source_i inside {3'h2, 3'h3, 3'h4}) [*3]
		|-> !clock_output_pin_oe_o) else $error("clock out with crystal");
	a_wake_hold:
	assert property (wake_i && cfg_source_i == 3'h4 |=> !cpu_clock_ready_o) else $error("no hold");
	a_wake_end:
	assert property ($fell(cpu_clock_ready_o) |-> ##[1:400] cpu_clock_ready_o) else $error("stuck");
endmodule
bind mcg_clock_gen mcg_sva u_sva (.*);

// >>> dv/tb_top.sv
// self-checking bench for the clock block
`timescale 1ns/1ns
module tb_top;
	logic core_clk_i = 0, rst_i = 1, por_i = 1, rtc_uses_xtal_i = 0, wake_i = 0;
	logic sfr_wr_i = 0, sfr_rd_i = 0, sfr_hit_o, cpu_clock_o, periph_clock_o, machine_cycle_o;
	logic clock_output_pin_o, clock_output_pin_oe_o, low_power_clock_select_o, cpu_clock_ready_o;
	logic rc_osc_clock_i, wdog_osc_clock_i, crystal_in_pin_i;
	logic [2:0] cfg_source_i = 0;
	logic [5:0] rc_osc_tune_o;
	logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, sfr_rdata_o, mdl [256];
	logic [7:0] adr [4] = '{8'h95, 8'h96, 8'hA2, 8'h90};
	logic [4:0] prv = 0;
	wire [4:0] cur = {cpu_clock_o, periph_clock_o, machine_cycle_o, clock_output_pin_o, rc_osc_clock_i};
	integer n_errors = 0, tests_run = 0, seed = 71, i, k, cnt [5];
	always #5 core_clk_i = ~core_clk_i;
	mcg_osc_model osc (.rc_o(rc_osc_clock_i), .wd_o(wdog_osc_clock_i), .xt_o(crystal_in_pin_i));
	// short wake counts keep the run brief
	mcg_clock_gen #(.WAKE_MIN_CYCLES(20), .WAKE_OSC_CYCLES(4)) uut (.*);
	always @(posedge core_clk_i)
	begin
		prv <= cur;
		for (int j = 0; j < 5; j++)
			cnt[j] <= cnt[j] + (cur[j] & !prv[j]);
	end
	function logic [7:0] msk(input logic [7:0] a);
		return a == 8'h95 ? 8'hFF : a == 8'h96 ? 8'h7F : a == 8'hA2 ? 8'h80 : 8'h00;
	endfunction
	function logic near(input integer a, b, t);
		return a - b <= t && b - a <= t;
	endfunction
	task chk(input string s, input logic [15:0] got, exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", s, exp, got);
		end
	endtask
	// strobes stay up between calls so back-to-back cycles need no idle edge
	task acc(input logic w, input logic [7:0] a, d);
		sfr_wr_i = w;
		sfr_rd_i = !w;
		sfr_addr_i = a;
		sfr_wdata_i = d;
		#1;
		chk("hit", sfr_hit_o, msk(a) != 0);
		if (w)
			mdl[a] = d & msk(a);
		else
			chk("rd", sfr_rdata_o, mdl[a]);
		@(negedge core_clk_i);
	endtask
	task meas(input integer n);
		repeat (40) @(negedge core_clk_i);
		for (k = 0; k < 5; k++)
			cnt[k] = 0;
		repeat (1200) @(negedge core_clk_i);
		chk("div", near(cnt[4] * (n ? 2 * n : 1), cnt[0], 2 * n + 2), 1);
		chk("pclk", near(cnt[3] * 2, cnt[4], 2), 1);
		chk("mcyc", near(cnt[2] * 2, cnt[4], 2), 1);
		chk("cout", near(cnt[1] * 2, cnt[4], 2), 1);
	endtask
	task results;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		foreach (mdl[j])
			mdl[j] = 0;
		mdl[8'h96] = 8'h20;
		repeat (8) @(negedge core_clk_i);
		rst_i = 0;
		por_i = 0;
		acc(0, 8'h96, 0);
		for (i = 0; i < 12; i++)
		begin
			k = $random(seed);
			acc(1, adr[i % 4], k[7:0]);
			acc(0, adr[i % 4], 0);
			chk("tune", rc_osc_tune_o, mdl[8'h96][5:0]);
			chk("lp", low_power_clock_select_o, mdl[8'hA2][7]);
		end
		sfr_rd_i = 0;
		rst_i = 1;
		@(negedge core_clk_i);
		rst_i = 0;
		mdl[8'h95] = 0;
		mdl[8'hA2] = 0;
		for (i = 0; i < 3; i++)
			acc(0, adr[i], 0);
		for (i = 0; i < 4; i++)
		begin
			acc(1, 8'h96, 8'h60);
			acc(1, 8'h95, i[7:0]);
			sfr_wr_i = 0;
			meas(i);
		end
		cfg_source_i = 3'h4;
		// source is registered inside, so let it settle before the wake pulse
		repeat (3) @(negedge core_clk_i);
		wake_i = 1;
		@(negedge core_clk_i);
		wake_i = 0;
		@(negedge core_clk_i);
		chk("hold", cpu_clock_ready_o, 0);
		chk("oe", clock_output_pin_oe_o, 0);
		for (k = 0; k < 400 && cpu_clock_ready_o !== 1; k++)
			@(negedge core_clk_i);
		chk("ready", cpu_clock_ready_o, 1);
		cfg_source_i = 3'h0;
		rtc_uses_xtal_i = 1;
		repeat (4) @(negedge core_clk_i);
		chk("oe", clock_output_pin_oe_o, 0);
		cfg_source_i = 3'h5;
		rtc_uses_xtal_i = 0;
		repeat (4) @(negedge core_clk_i);
		chk("oe", clock_output_pin_oe_o, 1);
		results();
	end
endmodule
